// ==== inc/sbcmd_pkg.sv ====
// constants, states and command decoding for the serial boot command handler
// assumes one 125 MHz clock and 8N1 serial framing on both pins
package sbcmd_pkg;
	// clock and serial timing
	localparam int CLK_MHZ = 125;
	localparam int BAUD_BASE = 9600;
	localparam int DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = 16'(CLK_MHZ * 1000000 / BAUD_BASE);
	// a zero byte holds the line low for start plus eight data bits
	localparam int CAL_MIN_US = 729;
	localparam int CAL_MIN_CLKS_DEF = CAL_MIN_US * CLK_MHZ;
	localparam int RUN_W = 18;
	localparam logic [4:0] CAL_LAST = 5'h0f;
	localparam logic [4:0] CAL_HALF = 5'h08;
	// nine low bit times, averaged over two runs
	localparam logic [RUN_W:0] CAL_DIVISOR = 19'h00012;
	// uart frame
	localparam logic [3:0] DATA_LAST = 4'h8;
	localparam logic [3:0] STOP_IDX = 4'h9;
	// command codes
	localparam logic [7:0] CMD_PAGE_READ = 8'hff;
	localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
	localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
	localparam logic [7:0] CMD_READ_STAT = 8'h70;
	localparam logic [7:0] CMD_CLR_STAT = 8'h50;
	localparam logic [7:0] CMD_LOCK_READ = 8'h71;
	localparam logic [7:0] CMD_ID_CHECK = 8'hf5;
	localparam logic [7:0] CMD_DOWNLOAD = 8'hfa;
	localparam logic [7:0] CMD_VERSION = 8'hfb;
	localparam logic [7:0] CMD_BOOT_READ = 8'hfc;
	localparam logic [7:0] CMD_BAUD_9600 = 8'hb0;
	localparam logic [7:0] CMD_BAUD_19200 = 8'hb1;
	localparam logic [7:0] CMD_BAUD_38400 = 8'hb2;
	localparam logic [7:0] CMD_BAUD_57600 = 8'hb3;
	localparam logic [7:0] ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] LOCK_UNLOCKED = 8'h01;
	// status bytes
	localparam logic [7:0] MAIN_STATUS_RST = 8'h80;
	localparam logic [1:0] ID_NOT = 2'b00;
	localparam logic [1:0] ID_BAD = 2'b01;
	localparam logic [1:0] ID_OK = 2'b11;
	// transfer lengths, as last index
	localparam logic [15:0] PAGE_LAST = 16'h00ff;
	localparam logic [15:0] ID_LAST = 16'h0006;
	localparam int ID_BYTES = 7;
	// main state machine, gray along cal, cmd, args, dispatch, send
	typedef enum logic [3:0] {
		ST_CAL = 4'h0,
		ST_CMD = 4'h1,
		ST_ARGS = 4'h3,
		ST_DISPATCH = 4'h2,
		ST_SEND = 4'h6,
		ST_SEND_WAIT = 4'h7,
		ST_RD_REQ = 4'h5,
		ST_RD_WAIT = 4'h4,
		ST_DATA_IN = 4'hc,
		ST_FLASH_WAIT = 4'hd,
		ST_BAUD_SET = 4'hf
	} sbcmd_state_type;
	// address or header bytes following the code
	function automatic logic [1:0] cmd_args(input logic [7:0] c);
		case (c)
			CMD_PAGE_READ, CMD_PAGE_PROG, CMD_LOCK_READ, CMD_BOOT_READ: cmd_args = 2'h2;
			CMD_ERASE_ALL: cmd_args = 2'h1;
			CMD_DOWNLOAD: cmd_args = 2'h3;
			CMD_ID_CHECK: cmd_args = 2'h0;
			default: cmd_args = 2'h0;
		endcase
	endfunction : cmd_args
	// commands refused until the id check passes
	function automatic logic cmd_gated(input logic [7:0] c);
		cmd_gated = c inside {CMD_PAGE_READ, CMD_PAGE_PROG, CMD_ERASE_ALL, CMD_CLR_STAT,
			CMD_LOCK_READ, CMD_DOWNLOAD, CMD_BOOT_READ};
	endfunction : cmd_gated
	// baud change codes
	function automatic logic cmd_baud(input logic [7:0] c);
		cmd_baud = c inside {CMD_BAUD_9600, CMD_BAUD_19200, CMD_BAUD_38400, CMD_BAUD_57600};
	endfunction : cmd_baud
	// every code that the handler knows
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = cmd_gated(c) || cmd_baud(c) || c inside {CMD_READ_STAT, CMD_ID_CHECK,
			CMD_VERSION};
	endfunction : cmd_known
	// divide of the 9600 base for each baud code
	function automatic logic [DIV_W-1:0] baud_factor(input logic [7:0] c);
		case (c)
			CMD_BAUD_19200: baud_factor = 16'h0002;
			CMD_BAUD_38400: baud_factor = 16'h0004;
			CMD_BAUD_57600: baud_factor = 16'h0006;
			default: baud_factor = 16'h0001;
		endcase
	endfunction : baud_factor
endpackage : sbcmd_pkg

// ==== rtl/sbcmd_rx.sv ====
// uart receiver, 8 data bits lsb first, one stop bit, no parity
// assumes the line is already synchronous to the clock
`timescale 1ns/1ns
module sbcmd_rx #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// line and bit period in clocks
	input wire logic i_rxd,
	input wire logic [DW-1:0] i_div,
	// received byte, one-cycle strobe
	output logic o_valid,
	output logic [7:0] o_data
);
	import sbcmd_pkg::*;
	logic busy_q; // inside a frame
	logic [DW-1:0] cnt_q; // clocks to next sample
	logic [3:0] bit_q; // 0 start, 1..8 data, 9 stop
	logic [7:0] sh_q; // data shift
	// frame sampler; starts half a bit in so samples sit mid-bit
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			o_valid <= 1'b0;
			o_data <= 8'h00;
		end else begin
			o_valid <= 1'b0;
			if (!busy_q) begin
				if (!i_rxd) begin
					busy_q <= 1'b1;
					cnt_q <= i_div >> 1;
					bit_q <= 4'h0;
				end
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end else begin
				cnt_q <= i_div - 1'b1;
				bit_q <= bit_q + 4'h1;
				if (bit_q == 4'h0) begin
					// glitch, not a start bit
					if (i_rxd) busy_q <= 1'b0;
				end else if (bit_q <= DATA_LAST) begin
					sh_q <= {i_rxd, sh_q[7:1]};
				end else begin
					// framing error drops the byte
					busy_q <= 1'b0;
					if (i_rxd) begin
						o_valid <= 1'b1;
						o_data <= sh_q;
					end
				end
			end
		end
	end
endmodule : sbcmd_rx

// ==== rtl/sbcmd_top.sv ====
// serial boot command handler: bit-rate calibration and command interpreter
// assumes a flash controller answers reads, writes and erases on plain strobes
`timescale 1ns/1ns
module sbcmd_top #(
	parameter int CAL_MIN_CLKS = sbcmd_pkg::CAL_MIN_CLKS_DEF,
	parameter logic [63:0] VERSION = 64'h5342_2d56_3031_3030 // arbitrary
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// serial link
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_busy,
	// flash read port
	output logic o_flash_rd,
	output logic o_flash_boot,
	output logic [23:0] o_flash_addr,
	input wire logic i_flash_ack,
	input wire logic [7:0] i_flash_data,
	// flash write and erase port
	output logic o_flash_wr,
	output logic [7:0] o_flash_wdata,
	output logic o_prog_start,
	output logic o_erase_start,
	input wire logic i_flash_done,
	input wire logic i_flash_err,
	// flash state and stored id
	input wire logic i_flash_blank,
	input wire logic [8*sbcmd_pkg::ID_BYTES-1:0] i_id_code,
	// download stream
	output logic o_dl_valid,
	output logic [7:0] o_dl_data,
	output logic o_dl_run,
	// status view
	output logic [7:0] o_main_status,
	output logic [7:0] o_aux_status
);
	import sbcmd_pkg::*;

	// main machine
	sbcmd_state_type state_q;
	logic [7:0] cmd_q; // command in progress
	logic [7:0] arg_q [0:3]; // bytes after the code
	logic [15:0] cnt_q; // byte index in phase
	logic [15:0] last_q; // last index in phase
	logic [7:0] rd_data_q; // byte fetched from flash
	logic tx_start_q; // strobe to transmitter
	logic [7:0] tx_data_q; // byte to transmitter
	logic tx_busy; // transmitter in frame
	logic rx_valid; // received byte strobe
	logic [7:0] rx_data; // received byte
	// calibration
	logic rxd_q; // previous line level
	logic [RUN_W-1:0] run_q; // low run length
	logic [RUN_W-1:0] min_q; // shortest early run
	logic [RUN_W-1:0] max_q; // longest late run
	logic [4:0] cal_n_q; // zero bytes seen
	logic cal_done_q; // calibration finished
	logic [DIV_W-1:0] base_q; // 9600 period
	logic [DIV_W-1:0] div_q; // active period
	// status
	logic ready_q; // flash not busy
	logic erase_err_q; // erase failed
	logic prog_err_q; // write failed
	logic boot_done_q; // download completed
	logic cksum_q; // download checksum matched
	logic [1:0] id_q; // id check result
	logic id_bad_q; // mismatch so far
	logic [7:0] sum_q; // download sum so far
	logic op_erase_q; // pending op is erase

	// decode helpers
	logic [7:0] main_status;
	logic [7:0] aux_status;
	logic accept;
	logic reading;
	logic tx_idle;
	logic at_last;
	logic [RUN_W-1:0] run_max;
	logic [RUN_W:0] cal_sum;
	logic [7:0] id_byte;
	logic id_miss;
	logic data_end;

	// status bytes as sent and shown
	assign main_status = {ready_q, 1'b0, erase_err_q, prog_err_q, 4'h0};
	assign aux_status = {boot_done_q, 2'b00, cksum_q, id_q, 2'b00};
	// blank flash lifts the id gate
	assign accept = cmd_known(rx_data) &&
		(!cmd_gated(rx_data) || id_q == ID_OK || i_flash_blank);
	assign reading = cmd_q == CMD_PAGE_READ || cmd_q == CMD_BOOT_READ;
	// transmitter free and no start in flight
	assign tx_idle = !tx_busy && !tx_start_q;
	assign at_last = cnt_q == last_q;
	// slowest late run including the closing one
	assign run_max = (run_q > max_q) ? run_q : max_q;
	assign cal_sum = {1'b0, min_q} + {1'b0, run_max};
	// stored id byte for the current index
	assign id_byte = i_id_code[{cnt_q[2:0], 3'b000} +: 8];
	assign id_miss = cnt_q > ID_LAST || rx_data != id_byte;
	assign data_end = state_q == ST_DATA_IN && rx_valid && at_last;

	// response byte for fixed-length answers
	function automatic logic [7:0] send_byte(input logic [7:0] c, input logic [15:0] i,
		input logic [7:0] ms, input logic [7:0] as, input logic [7:0] rd);
		case (c)
			CMD_READ_STAT: send_byte = (i == 16'h0000) ? ms : as;
			CMD_LOCK_READ: send_byte = LOCK_UNLOCKED;
			CMD_VERSION: send_byte = VERSION[{~i[2:0], 3'b000} +: 8];
			CMD_PAGE_READ, CMD_BOOT_READ: send_byte = rd;
			default: send_byte = c;
		endcase
	endfunction : send_byte

	// serial receiver on the active rate
	sbcmd_rx #(
		.DW(DIV_W)
	) u_rx (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_rxd(i_rxd),
		.i_div(div_q),
		.o_valid(rx_valid),
		.o_data(rx_data)
	);

	// serial transmitter, the only data path back to the programmer
	sbcmd_tx #(
		.DW(DIV_W)
	) u_tx (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_start(tx_start_q),
		.i_data(tx_data_q),
		.i_div(div_q),
		.o_txd(o_txd),
		.o_busy(tx_busy)
	);

	// calibration: time each long low run on the line
	// short runs such as a leading b0 are ignored by the length floor
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rxd_q <= 1'b1;
			run_q <= '0;
			min_q <= '1;
			max_q <= '0;
			cal_n_q <= 5'h00;
			cal_done_q <= 1'b0;
			base_q <= DIV_RESET;
		end else begin
			rxd_q <= i_rxd;
			cal_done_q <= 1'b0;
			// saturating run counter
			if (i_rxd) begin
				run_q <= '0;
			end else if (run_q != '1) begin
				run_q <= run_q + 1'b1;
			end
			// end of a zero byte's low time
			if (state_q == ST_CAL && i_rxd && !rxd_q && run_q >= RUN_W'(CAL_MIN_CLKS)) begin
				cal_n_q <= cal_n_q + 5'h01;
				if (cal_n_q < CAL_HALF) begin
					if (run_q < min_q) min_q <= run_q;
				end else begin
					max_q <= run_max;
				end
				if (cal_n_q == CAL_LAST) begin
					// mean of the two extremes over nine bit times
					base_q <= DIV_W'(cal_sum / CAL_DIVISOR);
					cal_done_q <= 1'b1;
				end
			end
		end
	end

	// active bit period; a baud code's rate change waits until its echo has left
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			div_q <= DIV_RESET;
		end else if (cal_done_q) begin
			// calibrated rate carries the b0 echo, not the nominal one
			div_q <= base_q;
		end else if (state_q == ST_BAUD_SET) begin
			div_q <= base_q / baud_factor(cmd_q);
		end
	end

	// command sequencer
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_q <= ST_CAL;
			cmd_q <= 8'h00;
			for (int i = 0; i < 4; i++) arg_q[i] <= 8'h00;
			cnt_q <= 16'h0000;
			last_q <= 16'h0000;
			rd_data_q <= 8'h00;
			tx_start_q <= 1'b0;
			tx_data_q <= 8'h00;
			o_flash_rd <= 1'b0;
			o_flash_boot <= 1'b0;
			o_flash_addr <= 24'h000000;
			o_flash_wr <= 1'b0;
			o_flash_wdata <= 8'h00;
			o_prog_start <= 1'b0;
			o_erase_start <= 1'b0;
			o_dl_valid <= 1'b0;
			o_dl_data <= 8'h00;
		end else begin
			// strobes last one cycle
			tx_start_q <= 1'b0;
			o_flash_rd <= 1'b0;
			o_flash_wr <= 1'b0;
			o_prog_start <= 1'b0;
			o_erase_start <= 1'b0;
			o_dl_valid <= 1'b0;
			case (state_q)
				// wait for the calibration run, then echo b0
				ST_CAL: begin
					if (cal_done_q) begin
						cmd_q <= CMD_BAUD_9600;
						cnt_q <= 16'h0000;
						last_q <= 16'h0000;
						state_q <= ST_SEND;
					end
				end
				// first byte is the command code
				ST_CMD: begin
					if (rx_valid && accept) begin
						cmd_q <= rx_data;
						cnt_q <= 16'h0000;
						state_q <= (cmd_args(rx_data) != 2'h0) ? ST_ARGS : ST_DISPATCH;
					end
					// anything else is dropped and the wait goes on
				end
				// address, size or confirm bytes
				ST_ARGS: begin
					if (rx_valid) begin
						arg_q[cnt_q[1:0]] <= rx_data;
						if (cnt_q[1:0] == cmd_args(cmd_q) - 2'h1) begin
							cnt_q <= 16'h0000;
							state_q <= ST_DISPATCH;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
				end
				// start the body of the command
				ST_DISPATCH: begin
					cnt_q <= 16'h0000;
					case (cmd_q)
						CMD_PAGE_READ, CMD_BOOT_READ: begin
							last_q <= PAGE_LAST;
							state_q <= ST_RD_REQ;
						end
						CMD_PAGE_PROG: begin
							last_q <= PAGE_LAST;
							state_q <= ST_DATA_IN;
						end
						CMD_ERASE_ALL: begin
							// only the confirm byte starts the erase
							if (arg_q[0] == ERASE_CONFIRM) begin
								o_erase_start <= 1'b1;
								state_q <= ST_FLASH_WAIT;
							end else begin
								state_q <= ST_CMD;
							end
						end
						CMD_ID_CHECK: begin
							// f5 collects three address bytes and the length here
							state_q <= ST_ARGS;
							cmd_q <= CMD_ID_CHECK;
						end
						CMD_DOWNLOAD: begin
							last_q <= {arg_q[1], arg_q[0]} - 16'h0001;
							state_q <= ({arg_q[1], arg_q[0]} == 16'h0000) ? ST_CMD : ST_DATA_IN;
						end
						CMD_READ_STAT: begin
							last_q <= 16'h0001;
							state_q <= ST_SEND;
						end
						CMD_VERSION: begin
							last_q <= 16'h0007;
							state_q <= ST_SEND;
						end
						CMD_LOCK_READ, CMD_BAUD_9600, CMD_BAUD_19200, CMD_BAUD_38400,
						CMD_BAUD_57600: begin
							last_q <= 16'h0000;
							state_q <= ST_SEND;
						end
						// clear acts in the status block
						default: state_q <= ST_CMD;
					endcase
				end
				// hand one byte to the transmitter
				ST_SEND: begin
					if (tx_idle) begin
						tx_start_q <= 1'b1;
						tx_data_q <= send_byte(cmd_q, cnt_q, main_status, aux_status, rd_data_q);
						state_q <= ST_SEND_WAIT;
					end
				end
				// wait for the frame to leave
				ST_SEND_WAIT: begin
					if (tx_idle) begin
						if (at_last) begin
							state_q <= cmd_baud(cmd_q) ? ST_BAUD_SET : ST_CMD;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
							state_q <= reading ? ST_RD_REQ : ST_SEND;
						end
					end
				end
				// fetch the next page byte, ascending address
				ST_RD_REQ: begin
					o_flash_rd <= 1'b1;
					o_flash_boot <= cmd_q == CMD_BOOT_READ;
					o_flash_addr <= {arg_q[1], arg_q[0], cnt_q[7:0]};
					state_q <= ST_RD_WAIT;
				end
				ST_RD_WAIT: begin
					if (i_flash_ack) begin
						rd_data_q <= i_flash_data;
						state_q <= ST_SEND;
					end
				end
				// inbound data phase of program, id check and download
				ST_DATA_IN: begin
					if (rx_valid) begin
						cnt_q <= cnt_q + 16'h0001;
						if (cmd_q == CMD_PAGE_PROG) begin
							o_flash_wr <= 1'b1;
							o_flash_wdata <= rx_data;
							o_flash_addr <= {arg_q[1], arg_q[0], cnt_q[7:0]};
						end
						if (cmd_q == CMD_DOWNLOAD) begin
							o_dl_valid <= 1'b1;
							o_dl_data <= rx_data;
						end
						if (at_last) begin
							o_prog_start <= cmd_q == CMD_PAGE_PROG;
							state_q <= (cmd_q == CMD_PAGE_PROG) ? ST_FLASH_WAIT : ST_CMD;
						end
					end
				end
				// busy until the flash reports completion
				ST_FLASH_WAIT: begin
					if (i_flash_done) state_q <= ST_CMD;
				end
				// new rate takes effect here
				ST_BAUD_SET: state_q <= ST_CMD;
				default: state_q <= ST_CMD;
			endcase
			// f5 header is four bytes; length zero fails at once
			if (state_q == ST_ARGS && rx_valid && cmd_q == CMD_ID_CHECK) begin
				arg_q[cnt_q[1:0]] <= rx_data;
				if (cnt_q[1:0] == 2'h3) begin
					cnt_q <= 16'h0000;
					last_q <= {8'h00, rx_data} - 16'h0001;
					state_q <= (rx_data == 8'h00) ? ST_CMD : ST_DATA_IN;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
					state_q <= ST_ARGS;
				end
			end
		end
	end

	// status flags; a completion in the clear cycle still sets its flag
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ready_q <= MAIN_STATUS_RST[7];
			erase_err_q <= 1'b0;
			prog_err_q <= 1'b0;
			boot_done_q <= 1'b0;
			cksum_q <= 1'b0;
			id_q <= ID_NOT;
			id_bad_q <= 1'b0;
			sum_q <= 8'h00;
			op_erase_q <= 1'b0;
			o_dl_run <= 1'b0;
		end else begin
			o_dl_run <= 1'b0;
			// clear, then let a coinciding error win
			if (state_q == ST_DISPATCH && cmd_q == CMD_CLR_STAT) begin
				erase_err_q <= 1'b0;
				prog_err_q <= 1'b0;
				boot_done_q <= 1'b0;
				cksum_q <= 1'b0;
			end
			// ready falls when an auto operation starts
			if (o_prog_start || o_erase_start) begin
				ready_q <= 1'b0;
				op_erase_q <= o_erase_start;
			end
			if (i_flash_done) begin
				ready_q <= 1'b1;
				if (i_flash_err && op_erase_q) erase_err_q <= 1'b1;
				if (i_flash_err && !op_erase_q) prog_err_q <= 1'b1;
			end
			// fresh accumulators for each data phase
			if (state_q == ST_DISPATCH || state_q == ST_ARGS) begin
				id_bad_q <= 1'b0;
				sum_q <= 8'h00;
			end
			if (state_q == ST_ARGS && rx_valid && cmd_q == CMD_ID_CHECK && cnt_q[1:0] == 2'h3
				&& rx_data == 8'h00) begin
				id_q <= ID_BAD;
			end
			if (state_q == ST_DATA_IN && rx_valid && cmd_q == CMD_ID_CHECK) begin
				id_bad_q <= id_bad_q | id_miss;
				if (at_last) begin
					// every byte must match and the length must be seven
					id_q <= (id_bad_q || id_miss || last_q != ID_LAST) ? ID_BAD : ID_OK;
				end
			end
			if (state_q == ST_DATA_IN && rx_valid && cmd_q == CMD_DOWNLOAD) begin
				sum_q <= sum_q + rx_data;
				if (data_end) begin
					cksum_q <= (sum_q + rx_data) == arg_q[2];
					boot_done_q <= (sum_q + rx_data) == arg_q[2];
					o_dl_run <= (sum_q + rx_data) == arg_q[2];
				end
			end
		end
	end

	// handshake line and status view
	// busy covers calibration, dispatch, flash operations and the rate change
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_busy <= 1'b1;
			o_main_status <= MAIN_STATUS_RST;
			o_aux_status <= 8'h00;
		end else begin
			o_busy <= state_q inside {ST_CAL, ST_DISPATCH, ST_FLASH_WAIT, ST_BAUD_SET};
			o_main_status <= main_status;
			o_aux_status <= aux_status;
		end
	end
endmodule : sbcmd_top

// ==== rtl/sbcmd_tx.sv ====
// uart transmitter, 8 data bits lsb first, one stop bit, no parity
// assumes i_start is only raised while o_busy is low
`timescale 1ns/1ns
module sbcmd_tx #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// byte to send and bit period
	input wire logic i_start,
	input wire logic [7:0] i_data,
	input wire logic [DW-1:0] i_div,
	// line and state
	output logic o_txd,
	output logic o_busy
);
	import sbcmd_pkg::*;
	logic [8:0] sh_q; // data then stop
	logic [DW-1:0] cnt_q; // clocks left in bit
	logic [3:0] bit_q; // bit on the line
	// frame shifter; line idles high
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_txd <= 1'b1;
			o_busy <= 1'b0;
			sh_q <= 9'h1ff;
			cnt_q <= '0;
			bit_q <= 4'h0;
		end else if (!o_busy) begin
			if (i_start) begin
				o_busy <= 1'b1;
				o_txd <= 1'b0;
				sh_q <= {1'b1, i_data};
				cnt_q <= i_div - 1'b1;
				bit_q <= 4'h0;
			end
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else if (bit_q == STOP_IDX) begin
			o_busy <= 1'b0;
		end else begin
			o_txd <= sh_q[0];
			sh_q <= {1'b1, sh_q[8:1]};
			bit_q <= bit_q + 4'h1;
			cnt_q <= i_div - 1'b1;
		end
	end
endmodule : sbcmd_tx

// ==== test/sbcmd_chk_assertions.sv ====
// port checker for the boot command handler
// assumes a bind from the bench top onto sbcmd_top
`timescale 1ns/1ns
module sbcmd_chk (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// serial side
	input wire logic o_txd,
	input wire logic o_busy,
	// flash and download strobes
	input wire logic o_flash_rd,
	input wire logic o_prog_start,
	input wire logic o_erase_start,
	input wire logic o_dl_valid,
	// status view
	input wire logic [7:0] o_main_status,
	input wire logic [7:0] o_aux_status
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// reset levels, checked while reset is held
	AST_RST: assert property (disable iff (1'b0) !i_rst_n |=> o_txd && o_busy && o_main_status == 8'h80)
		else $error("bad reset levels");
	AST_MAIN_RSV: assert property (o_main_status[6] == 1'b0 && o_main_status[3:0] == 4'h0)
		else $error("main status reserved bit set");
	AST_AUX_RSV: assert property (o_aux_status[6:5] == 2'h0 && o_aux_status[3:2] != 2'b10)
		else $error("aux status bad field");
	AST_ID_OK: assert property ($rose(o_aux_status[3]) |-> o_aux_status[2])
		else $error("id result not 11");
	AST_PROG: assert property (o_prog_start |-> ##[1:2] !o_main_status[7])
		else $error("ready high in write");
	AST_ERASE: assert property (o_erase_start |-> ##[1:2] !o_main_status[7])
		else $error("ready high in erase");
	AST_RD: assert property (o_flash_rd |=> !o_flash_rd)
		else $error("read strobe too long");
	AST_DL: assert property (o_dl_valid |=> !o_dl_valid)
		else $error("download strobe too long");
	// main scenarios
	cover property (o_aux_status[3:2] == 2'b11);
	cover property ($fell(o_busy));
	cover property ($fell(o_txd));
endmodule : sbcmd_chk

// ==== test/sbcmd_prog.sv ====
// programmer model: 8n1 lsb first on both pins
// assumes the bench gives the bit period in clocks
`timescale 1ns/1ns
module sbcmd_prog (
	// device side
	input wire logic i_clock,
	input wire logic i_txd,
	output logic o_rxd
);
	initial o_rxd = 1'b1; // idle high
	// one frame out at falling edges
	task automatic send(input logic [7:0] b, input int d);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge i_clock) o_rxd = f[i];
			repeat (d - 1) @(negedge i_clock);
		end
	endtask : send
	// one frame in, mid bit; got low when no start bit came
	task automatic recv(output logic [7:0] b, output logic got, input int d);
		int n;
		n = 0;
		b = 8'h00;
		// falling edges keep clear of the edge that launches the line
		while (i_txd === 1'b1 && n < 30 * d) begin
			@(negedge i_clock);
			n++;
		end
		got = (n < 30 * d);
		if (got) begin
			repeat (d / 2) @(negedge i_clock);
			for (int i = 0; i < 8; i++) begin
				repeat (d) @(negedge i_clock);
				b[i] = i_txd; // lsb first
			end
			repeat (d) @(negedge i_clock);
		end
	endtask : recv
endmodule : sbcmd_prog

// ==== test/sbcmd_top_tb_top.sv ====
// bench for the boot command handler
// assumes the programmer model in sbcmd_prog
`timescale 1ns/1ns
module sbcmd_top_tb_top;
	import sbcmd_pkg::*;
	localparam logic [63:0] VER = 64'h0123_4567_89ab_cdef; // arbitrary
	localparam logic [55:0] ID = 56'h11_2233_4455_6677; // arbitrary
	logic i_clock, i_rst_n, blank, got;
	logic rxd, txd, busy, fdone;
	logic [7:0] ms, as, dld;
	logic [7:0] rb [8];
	int n_mismatch, num_checks, dv;
	sbcmd_top #(.CAL_MIN_CLKS(200), .VERSION(VER)) sbcmd_top_i (.i_clock, .i_rst_n,
		.i_rxd(rxd), .o_txd(txd), .o_busy(busy), .o_flash_rd(), .o_flash_boot(),
		.o_flash_addr(), .i_flash_ack(1'b0), .i_flash_data(8'h00), .o_flash_wr(),
		.o_flash_wdata(), .o_prog_start(), .o_erase_start(), .i_flash_done(fdone),
		.i_flash_err(fdone), .i_flash_blank(blank), .i_id_code(ID), .o_dl_valid(),
		.o_dl_data(dld), .o_dl_run(), .o_main_status(ms), .o_aux_status(as));
	sbcmd_prog sbcmd_prog_i (.i_clock, .i_txd(txd), .o_rxd(rxd));
	// compare one byte
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic tx(input logic [7:0] c);
		sbcmd_prog_i.send(c, dv);
	endtask : tx
	// code out while up to nr answers come back
	task automatic xfer(input logic [7:0] c, input int nr);
		fork
			tx(c);
			for (int k = 0; k < nr; k++) sbcmd_prog_i.recv(rb[k], got, dv);
		join
	endtask : xfer
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// zero runs of 360 clocks give a 40 clock bit, then b0 echo
	task automatic t_cal;
		repeat (15) tx(8'h00);
		xfer(8'h00, 1);
		chk(rb[0], 8'hb0);
		dv = 40;
	endtask : t_cal
	// unknown code dropped, status pair follows
	task automatic t_stat;
		tx(8'h12);
		xfer(8'h70, 2);
		chk(rb[0], 8'h80);
		chk(rb[1], 8'h00);
	endtask : t_stat
	// lock read: open on blank flash or after the id check passes, refused otherwise
	task automatic t_lock(input logic bl, input logic [7:0] e);
		blank = bl;
		tx(8'h71);
		tx(8'h01);
		xfer(8'h00, 1);
		chk({7'h00, got}, e);
		if (got)
			chk(rb[0], LOCK_UNLOCKED);
	endtask : t_lock
	// id check, length 0 fails, full id passes
	task automatic t_id(input logic [7:0] n, input logic [1:0] e);
		tx(8'hf5);
		repeat (3) tx(8'h00);
		tx(n);
		for (int k = 0; k < n; k++) tx(ID[8*k+:8]);
		repeat (8) @(negedge i_clock);
		chk({6'h00, as[3:2]}, {6'h00, e});
	endtask : t_id
	// erase on a failing flash; ready low until done, then error shown
	task automatic t_erase;
		tx(8'ha7);
		tx(8'hd0);
		repeat (4) @(negedge i_clock);
		chk(ms, 8'h00);
		chk({7'h00, busy}, 8'h01);
		fdone = 1'b1;
		@(negedge i_clock);
		fdone = 1'b0;
		repeat (4) @(negedge i_clock);
		chk(ms, 8'ha0);
	endtask : t_erase
	// one byte download whose checksum matches
	task automatic t_dl;
		tx(8'hfa);
		tx(8'h01);
		tx(8'h00);
		tx(8'h5a);
		tx(8'h5a);
		repeat (8) @(negedge i_clock);
		chk(as, 8'h9c);
		chk(dld, 8'h5a);
	endtask : t_dl
	// clear keeps id, drops erase and download flags, busy low after
	task automatic t_clr;
		tx(8'h50);
		repeat (20) @(negedge i_clock);
		chk({7'h00, busy}, 8'h00);
		chk(as, 8'h0c);
		chk(ms, 8'h80);
	endtask : t_clr
	task automatic t_ver;
		xfer(8'hfb, 8);
		for (int k = 0; k < 8; k++) chk(rb[k], VER[63-8*k-:8]);
	endtask : t_ver
	// echo at old rate, then half the bit time
	task automatic t_baud;
		xfer(8'hb1, 1);
		chk(rb[0], 8'hb1);
		// let the echo's stop bit finish before the rate moves
		repeat (40) @(negedge i_clock);
		dv = 20;
		xfer(8'h70, 1);
		chk(rb[0], 8'h80);
	endtask : t_baud
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	// watchdog at about three times the expected 30k cycles
	initial begin
		#800000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		dv = 40;
		blank = 1'b0;
		fdone = 1'b0;
		i_rst_n = 1'b0;
		repeat (4) @(negedge i_clock);
		i_rst_n = 1'b1;
		t_cal();
		t_stat();
		t_lock(1'b1, 8'h01);
		t_lock(1'b0, 8'h00);
		t_id(8'h00, 2'b01);
		t_id(8'h07, 2'b11);
		t_lock(1'b0, 8'h01);
		t_erase();
		t_dl();
		t_clr();
		t_ver();
		t_baud();
		end_sim();
	end
endmodule : sbcmd_top_tb_top
bind sbcmd_top sbcmd_chk sbcmd_chk_i (.i_clock, .i_rst_n, .o_txd, .o_busy, .o_flash_rd,
	.o_prog_start, .o_erase_start, .o_dl_valid, .o_main_status, .o_aux_status);
